// ### hdl/display_timing_pkg.sv
// Constants, register map and types for the teletext display timing block
package display_timing_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Register port
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [2:0] ADDR_DISPLAY_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_SYNC_CONFIG = 3'h1;
  localparam logic [2:0] ADDR_DISPLAY_OPTION = 3'h2;
  localparam logic [2:0] ADDR_ACTIVE_ROW = 3'h3;
  localparam logic [2:0] ADDR_ACTIVE_COLUMN = 3'h4;
  localparam logic [2:0] ADDR_DISPLAY_POSITION = 3'h5;
  localparam logic [2:0] ADDR_COLOUR_LOOKUP = 3'h6;
  localparam logic [2:0] ADDR_STATUS = 3'h7;

  // display_control_reg fields
  localparam int unsigned CTRL_STATUS_ROW_ONLY_BIT = 0;
  localparam int unsigned CTRL_EXT_PROMPT_BIT = 1;
  localparam int unsigned CTRL_DEINT_FORCE_LOW_BIT = 2;
  localparam int unsigned CTRL_DEINT_AUTO_BIT = 3;
  localparam int unsigned CTRL_VIDEO_SHOWN_BIT = 4;
  // sync_config_reg fields
  localparam int unsigned SYNC_H_POL_BIT = 0;
  localparam int unsigned SYNC_V_POL_BIT = 1;
  localparam int unsigned SYNC_FIELD_INV_BIT = 2;
  localparam int unsigned SYNC_LINES_525_BIT = 3;
  // display_option_reg fields
  localparam int unsigned OPT_CURSOR_ON_BIT = 0;
  localparam int unsigned OPT_ENLARGE_BIT = 1;
  localparam int unsigned OPT_HALF_SELECT_BIT = 2;
  // active_row_reg freeze bit; colour_lookup_table write fields
  localparam int unsigned ROW_FREEZE_BIT = 7;
  localparam int unsigned COLOUR_LOOKUP_TABLE_ADDR_SEL_BIT = 7;
  localparam int unsigned COLOUR_LOOKUP_TABLE_ENABLE_BIT = 6;
  // display_position_reg fields
  localparam int unsigned POS_HORIZ_LSB = 0;
  localparam int unsigned POS_VERT_LSB = 2;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SYNC_RESET = 8'h00;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [7:0] POS_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Horizontal timing
  localparam int unsigned HSTART_DEFAULT_NS = 17200;
  localparam int unsigned HSTART_STEP_NS = 1000;
  localparam int unsigned DISPLAY_WIDTH_NS = 40000;
  localparam int unsigned HSTART_DEFAULT_CYC = (HSTART_DEFAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HSTART_STEP_CYC = HSTART_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned DISPLAY_WIDTH_CYC = DISPLAY_WIDTH_NS / CLK_PERIOD_NS;
  localparam int unsigned COLUMNS = 40;
  localparam int unsigned COLUMN_CYC = DISPLAY_WIDTH_CYC / COLUMNS;
  localparam int unsigned HCOUNT_W = 13;
  localparam logic [12:0] HCOUNT_MAX = 13'h1FFF;

  // Field decision windows, line sync to field sync
  localparam int unsigned HV_EVEN_END_NS = 16000;
  localparam int unsigned HV_HOLD_END_NS = 32000;
  localparam int unsigned HV_ODD_END_NS = 48000;

  // Vertical timing
  localparam int unsigned DISPLAY_LINES = 250;
  localparam int unsigned SCANS_PER_ROW = 10;
  localparam logic [4:0] STATUS_ROW = 5'h18;
  localparam logic [4:0] HALF_FIRST_ROW = 5'h0C;
  localparam logic [4:0] TOP_LAST_ROW = 5'h0B;
  localparam int unsigned V625_BASE_LO = 42;
  localparam int unsigned V625_BASE_HI = 34;
  localparam int unsigned V525_BASE_LO = 28;
  localparam int unsigned V525_BASE_HI = 20;
  localparam int unsigned VSTEP_LINES = 2;
  localparam logic [9:0] LINE_MAX = 10'h3FF;

  // Colour table
  localparam int unsigned COLOUR_LOOKUP_TABLE_ENTRIES = 16;
  localparam int unsigned COLOUR_LOOKUP_TABLE_W = 6;

  typedef enum logic [1:0] {V_WAIT, V_ACTIVE, V_DONE} v_state_t;
endpackage

// ### hdl/teletext_display_timing.sv
// Teletext display timing, cursor, enlargement and colour table logic
// Behaviour
// - Sixteen colour entries: foregrounds 0-7, backgrounds 8-F.
// - Each entry six bits, two per component.
// - Cursor swaps foreground and background indices, before table lookup, at active row and column.
// - Freeze holds cursor position despite register changes.
// - Enlarge doubles character height over display.
// - Enlarge shows rows 0-11 or 12-24.
// - Status-row-only hides rows 0 to 23.
// - Option sources row 24 from extension memory.
// - Packet 27 link bit 3 reverts row 24.
// - Polarity bit picks rising or falling edge.
// - Horizontal timing restarts on every line sync.
// - Default display starts 17.2 us, lasts 40 us.
// - Vertical restarts per field; 250 lines maximum.
// - Line-to-field delay window picks de-interlace value.
// - Force-low bit holds de-interlace output low.
// - Auto mode forces low while video shown.
// - Field inversion shifts start, not de-interlace output.
// - Horizontal offset code selects 17.2 to 14.2 us.
// - Vertical offset code selects first display line.
// - Opposite field starts on equivalent line.
// - Active-high reset initialises all logic.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module teletext_display_timing
  import display_timing_pkg::*;
#(
  parameter int unsigned HV_EVEN_END_CYC = HV_EVEN_END_NS / CLK_PERIOD_NS,
  parameter int unsigned HV_HOLD_END_CYC = HV_HOLD_END_NS / CLK_PERIOD_NS,
  parameter int unsigned HV_ODD_END_CYC = HV_ODD_END_NS / CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic link_prompt_revert,
  input wire logic [2:0] fg_index,
  input wire logic [2:0] bg_index,
  output logic disp_active,
  output logic [4:0] disp_row,
  output logic [5:0] disp_col,
  output logic [3:0] char_scan,
  output logic prompt_from_ext,
  output logic cell_highlight,
  output logic [5:0] fg_colour,
  output logic [5:0] bg_colour,
  output logic deinterlace_out
);

  typedef struct packed {
    logic hs_meta;
    logic hs_sync;
    logic hs_prev;
    logic vs_meta;
    logic vs_sync;
    logic vs_prev;
    logic [7:0] ctrl;
    logic [7:0] sync_cfg;
    logic [7:0] opt;
    logic [7:0] arow;
    logic [7:0] acol;
    logic [7:0] pos;
    logic [3:0] colour_lookup_table_addr;
    logic colour_lookup_table_en;
    logic [COLOUR_LOOKUP_TABLE_ENTRIES-1:0][COLOUR_LOOKUP_TABLE_W-1:0] colour_lookup_table;
    logic [7:0] rdata;
    logic [12:0] hcount;
    logic hrun;
    logic [5:0] col;
    logic [6:0] colsub;
    logic [9:0] line;
    v_state_t vstate;
    logic [4:0] row;
    logic [4:0] scan;
    logic [8:0] shown;
    logic field;
    logic [4:0] cur_row;
    logic [5:0] cur_col;
    logic pix;
    logic ext;
    logic hl;
    logic [5:0] fg;
    logic [5:0] bg;
    logic deint;
  } st_t;

  st_t s;
  st_t n;

  logic h_edge;
  logic v_edge;
  logic enlarge;
  logic [12:0] hstart_c;
  logic [9:0] vfirst_c;
  logic [9:0] vbase_c;
  logic [4:0] row_first_c;
  logic [4:0] row_last_c;
  logic [4:0] scan_last_c;
  logic hl_c;
  logic [2:0] fg_sel;
  logic [2:0] bg_sel;

  // Full-intensity colour or table entry; layout {blue, green, red}
  function automatic logic [5:0] colour_of(input logic [2:0] idx, input logic is_bg,
                                           input logic en,
                                           input logic [COLOUR_LOOKUP_TABLE_ENTRIES-1:0][COLOUR_LOOKUP_TABLE_W-1:0] tbl);
    logic [5:0] c;
    c = {idx[2], idx[2], idx[1], idx[1], idx[0], idx[0]};
    if (en) begin
      c = tbl[{is_bg, idx}];
    end
    return c;
  endfunction

  // Edge selection on synchronised levels
  assign h_edge = s.sync_cfg[SYNC_H_POL_BIT] ? (s.hs_prev & ~s.hs_sync)
                                             : (~s.hs_prev & s.hs_sync);
  assign v_edge = s.sync_cfg[SYNC_V_POL_BIT] ? (s.vs_prev & ~s.vs_sync)
                                             : (~s.vs_prev & s.vs_sync);
  assign enlarge = s.opt[OPT_ENLARGE_BIT];
  assign hstart_c = 13'(HSTART_DEFAULT_CYC
                        - HSTART_STEP_CYC * int'(s.pos[POS_HORIZ_LSB +: 2]));

  always_comb begin
    if (s.sync_cfg[SYNC_LINES_525_BIT]) begin
      vbase_c = s.pos[POS_VERT_LSB + 2] ? 10'(V525_BASE_HI) : 10'(V525_BASE_LO);
    end else begin
      vbase_c = s.pos[POS_VERT_LSB + 2] ? 10'(V625_BASE_HI) : 10'(V625_BASE_LO);
    end
  end

  // Same line number on both fields; inversion delays the assumed late field
  assign vfirst_c = 10'(int'(vbase_c) + VSTEP_LINES * int'(s.pos[POS_VERT_LSB +: 2])
                        + int'(s.sync_cfg[SYNC_FIELD_INV_BIT] & ~s.field));

  assign row_first_c = (enlarge && s.opt[OPT_HALF_SELECT_BIT]) ? HALF_FIRST_ROW : 5'h00;
  assign row_last_c = (enlarge && !s.opt[OPT_HALF_SELECT_BIT]) ? TOP_LAST_ROW : STATUS_ROW;
  assign scan_last_c = enlarge ? 5'(2 * SCANS_PER_ROW - 1) : 5'(SCANS_PER_ROW - 1);

  assign hl_c = s.opt[OPT_CURSOR_ON_BIT] && (s.row == s.cur_row) && (s.col == s.cur_col);
  assign fg_sel = hl_c ? bg_index : fg_index;
  assign bg_sel = hl_c ? fg_index : bg_index;

  always_comb begin
    n = s;
    n.hs_meta = hsync_in;
    n.hs_sync = s.hs_meta;
    n.hs_prev = s.hs_sync;
    n.vs_meta = vsync_in;
    n.vs_sync = s.vs_meta;
    n.vs_prev = s.vs_sync;

    // Register writes
    if (reg_wr) begin
      if (reg_addr == ADDR_DISPLAY_CONTROL) begin
        n.ctrl = reg_wdata;
      end else if (reg_addr == ADDR_SYNC_CONFIG) begin
        n.sync_cfg = reg_wdata;
      end else if (reg_addr == ADDR_DISPLAY_OPTION) begin
        n.opt = reg_wdata;
      end else if (reg_addr == ADDR_ACTIVE_ROW) begin
        n.arow = reg_wdata;
      end else if (reg_addr == ADDR_ACTIVE_COLUMN) begin
        n.acol = reg_wdata;
      end else if (reg_addr == ADDR_DISPLAY_POSITION) begin
        n.pos = reg_wdata;
      end else if (reg_addr == ADDR_COLOUR_LOOKUP) begin
        n.colour_lookup_table_en = reg_wdata[COLOUR_LOOKUP_TABLE_ENABLE_BIT];
        if (reg_wdata[COLOUR_LOOKUP_TABLE_ADDR_SEL_BIT]) begin
          n.colour_lookup_table_addr = reg_wdata[3:0];
        end else begin
          n.colour_lookup_table[s.colour_lookup_table_addr] = reg_wdata[COLOUR_LOOKUP_TABLE_W-1:0];
        end
      end
    end

    // Register reads, data one cycle later
    n.rdata = READ_IDLE;
    if (reg_rd) begin
      if (reg_addr == ADDR_DISPLAY_CONTROL) begin
        n.rdata = s.ctrl;
      end else if (reg_addr == ADDR_SYNC_CONFIG) begin
        n.rdata = s.sync_cfg;
      end else if (reg_addr == ADDR_DISPLAY_OPTION) begin
        n.rdata = s.opt;
      end else if (reg_addr == ADDR_ACTIVE_ROW) begin
        n.rdata = s.arow;
      end else if (reg_addr == ADDR_ACTIVE_COLUMN) begin
        n.rdata = s.acol;
      end else if (reg_addr == ADDR_DISPLAY_POSITION) begin
        n.rdata = s.pos;
      end else if (reg_addr == ADDR_COLOUR_LOOKUP) begin
        n.rdata = {1'b0, s.colour_lookup_table_en, 2'b00, s.colour_lookup_table_addr};
      end else if (reg_addr == ADDR_STATUS) begin
        n.rdata = {4'h0, s.hrun, s.vstate == V_ACTIVE, s.deint, s.field};
      end
    end

    // Horizontal counter and columns
    if (h_edge) begin
      n.hcount = '0;
      n.hrun = 1'b0;
    end else begin
      if (s.hcount != HCOUNT_MAX) begin
        n.hcount = s.hcount + 13'h0001;
      end
      if (s.hcount == hstart_c) begin
        n.hrun = 1'b1;
        n.col = '0;
        n.colsub = '0;
      end else if (s.hrun) begin
        if (s.colsub == 7'(COLUMN_CYC - 1)) begin
          n.colsub = '0;
          if (s.col == 6'(COLUMNS - 1)) begin
            n.hrun = 1'b0;
          end else begin
            n.col = s.col + 6'h01;
          end
        end else begin
          n.colsub = s.colsub + 7'h01;
        end
      end
    end

    // Vertical sequencing
    if (v_edge) begin
      n.line = '0;
      n.vstate = V_WAIT;
      if (s.hcount < HV_EVEN_END_CYC) begin
        n.field = 1'b0;
      end else if (s.hcount < HV_HOLD_END_CYC) begin
        n.field = s.field;
      end else if (s.hcount < HV_ODD_END_CYC) begin
        n.field = 1'b1;
      end
    end else if (h_edge) begin
      if (s.line != LINE_MAX) begin
        n.line = s.line + 10'h001;
      end
      case (s.vstate)
        V_WAIT: begin
          if (s.line + 10'h001 == vfirst_c) begin
            n.vstate = V_ACTIVE;
            n.row = row_first_c;
            n.scan = '0;
            n.shown = '0;
          end
        end
        V_ACTIVE: begin
          n.shown = s.shown + 9'h001;
          if (s.shown + 9'h001 == 9'(DISPLAY_LINES)) begin
            n.vstate = V_DONE;
          end else if (s.scan == scan_last_c) begin
            n.scan = '0;
            if (s.row == row_last_c) begin
              n.vstate = V_DONE;
            end else begin
              n.row = s.row + 5'h01;
            end
          end else begin
            n.scan = s.scan + 5'h01;
          end
        end
        default: begin
          n.vstate = V_DONE;
        end
      endcase
    end

    // Cursor position follows active row and column unless frozen
    if (!s.arow[ROW_FREEZE_BIT]) begin
      n.cur_row = s.arow[4:0];
      n.cur_col = s.acol[5:0];
    end

    // Registered display outputs
    n.pix = s.hrun && (s.vstate == V_ACTIVE)
            && !(s.ctrl[CTRL_STATUS_ROW_ONLY_BIT] && (s.row != STATUS_ROW));
    n.ext = s.ctrl[CTRL_EXT_PROMPT_BIT] && (s.row == STATUS_ROW)
            && !link_prompt_revert;
    n.hl = hl_c;
    n.fg = colour_of(fg_sel, 1'b0, s.colour_lookup_table_en, s.colour_lookup_table);
    n.bg = colour_of(bg_sel, 1'b1, s.colour_lookup_table_en, s.colour_lookup_table);
    if (s.ctrl[CTRL_DEINT_FORCE_LOW_BIT]) begin
      n.deint = 1'b0;
    end else if (s.ctrl[CTRL_DEINT_AUTO_BIT] && s.ctrl[CTRL_VIDEO_SHOWN_BIT]) begin
      n.deint = 1'b0;
    end else begin
      n.deint = s.field;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.sync_cfg <= SYNC_RESET;
      s.opt <= OPT_RESET;
      s.pos <= POS_RESET;
      s.vstate <= V_WAIT;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign disp_active = s.pix;
  assign disp_row = s.row;
  assign disp_col = s.col;
  assign char_scan = enlarge ? s.scan[4:1] : s.scan[3:0];
  assign prompt_from_ext = s.ext;
  assign cell_highlight = s.hl;
  assign fg_colour = s.fg;
  assign bg_colour = s.bg;
  assign deinterlace_out = s.deint;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_force_low;
    s.ctrl[CTRL_DEINT_FORCE_LOW_BIT] |=> !deinterlace_out;
  endproperty
  a_force_low: assert property (p_force_low) else $error("deinterlace not forced low");

  property p_auto_video;
    s.ctrl[CTRL_DEINT_AUTO_BIT] && s.ctrl[CTRL_VIDEO_SHOWN_BIT] |=> !deinterlace_out;
  endproperty
  a_auto_video: assert property (p_auto_video) else $error("deinterlace high with video");

  property p_field_even;
    v_edge && (s.hcount < HV_EVEN_END_CYC) |=> !s.field;
  endproperty
  a_field_even: assert property (p_field_even) else $error("early field sync not even");

  property p_field_odd;
    v_edge && (s.hcount >= HV_HOLD_END_CYC) && (s.hcount < HV_ODD_END_CYC) |=> s.field;
  endproperty
  a_field_odd: assert property (p_field_odd) else $error("mid field sync not odd");

  property p_field_window_hold;
    v_edge && (s.hcount >= HV_EVEN_END_CYC) && (s.hcount < HV_HOLD_END_CYC) |=> $stable(s.field);
  endproperty
  a_field_window_hold: assert property (p_field_window_hold) else $error("field changed in hold");

  property p_field_held;
    !v_edge |=> $stable(s.field);
  endproperty
  a_field_held: assert property (p_field_held) else $error("field changed between syncs");

  property p_freeze;
    s.arow[ROW_FREEZE_BIT] |=> $stable(s.cur_row) && $stable(s.cur_col);
  endproperty
  a_freeze: assert property (p_freeze) else $error("cursor moved while frozen");

  property p_status_only;
    s.ctrl[CTRL_STATUS_ROW_ONLY_BIT] && (s.row != STATUS_ROW) |=> !disp_active;
  endproperty
  a_status_only: assert property (p_status_only) else $error("row shown in status-only mode");

  property p_prompt_revert;
    link_prompt_revert |=> !prompt_from_ext;
  endproperty
  a_prompt_revert: assert property (p_prompt_revert) else $error("prompt row not reverted");

  property p_hstart;
    $rose(s.hrun) |-> $past(s.hcount) == $past(hstart_c);
  endproperty
  a_hstart: assert property (p_hstart) else $error("display window started off time");

  c_field_odd: cover property ($rose(s.field));
  c_display_on: cover property ($rose(disp_active));
  c_prompt_ext: cover property ($rose(prompt_from_ext));
  c_enlarge_bottom: cover property (enlarge && s.opt[OPT_HALF_SELECT_BIT] && disp_active);

endmodule
`default_nettype wire

// ### sim/sync_source.sv
// Line and field sync source standing in for the deflection circuits
`timescale 1ns/1ps
`default_nettype none
module sync_source (
  input wire logic core_clk,
  input wire logic h_pol,
  input wire logic v_pol,
  output logic hsync_in,
  output logic vsync_in
);
  logic h_act = 1'b0;
  logic v_act = 1'b0;

  // Pins rest at the inactive level of the chosen polarity
  assign hsync_in = h_act ^ h_pol;
  assign vsync_in = v_act ^ v_pol;

  task automatic line(input int len);
    h_act <= 1'b1;
    repeat (8) @(posedge core_clk);
    h_act <= 1'b0;
    repeat (len - 8) @(posedge core_clk);
  endtask

  // Field sync active edge lands d cycles after the line sync active edge
  task automatic field(input int d, input int len);
    h_act <= 1'b1;
    repeat (8) @(posedge core_clk);
    h_act <= 1'b0;
    repeat (d - 8) @(posedge core_clk);
    v_act <= 1'b1;
    repeat (8) @(posedge core_clk);
    v_act <= 1'b0;
    repeat (len - d - 8) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ### sim/teletext_display_timing_tb.sv
// Self-checking bench for the teletext display timing block
`timescale 1ns/1ps
`default_nettype none
module teletext_display_timing_tb;
  import display_timing_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic hsync_in;
  logic vsync_in;
  logic link_prompt_revert = 1'b0;
  logic [2:0] fg_index = 3'h0;
  logic [2:0] bg_index = 3'h0;
  logic disp_active;
  logic [4:0] disp_row;
  logic [5:0] disp_col;
  logic [3:0] char_scan;
  logic prompt_from_ext;
  logic cell_highlight;
  logic [5:0] fg_colour;
  logic [5:0] bg_colour;
  logic deinterlace_out;
  logic h_pol = 1'b0;
  logic v_pol = 1'b0;
  int bad_count = 0;
  int checks_done = 0;
  int k;
  logic [7:0] rv;
  logic [5:0] colour_lookup_table_val [16];
  logic [7:0] wv [6] = '{8'h1F, 8'h0F, 8'h07, 8'h9F, 8'h27, 8'h1F};
  logic [7:0] vcfg [5] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00};
  logic [7:0] vpos [5] = '{8'h00, 8'h10, 8'h0C, 8'h1C, 8'h00};
  int vfirst [5] = '{42, 34, 34, 26, 42};
  int vd [5] = '{50, 50, 50, 50, 400};
  logic [7:0] fctrl [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h04, 8'h18, 8'h08, 8'h00, 8'h00};
  logic [7:0] fsync [11] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02,
                             8'h02, 8'h02, 8'h02, 8'h06, 8'h06};
  int fd [11] = '{400, 200, 50, 550, 400, 550, 400, 400, 400, 50, 400};
  logic fexp [11] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  teletext_display_timing #(
    .HV_EVEN_END_CYC(160), .HV_HOLD_END_CYC(320), .HV_ODD_END_CYC(480)
  ) teletext_display_timing_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hsync_in(hsync_in),
    .vsync_in(vsync_in), .link_prompt_revert(link_prompt_revert), .fg_index(fg_index),
    .bg_index(bg_index), .disp_active(disp_active), .disp_row(disp_row),
    .disp_col(disp_col), .char_scan(char_scan), .prompt_from_ext(prompt_from_ext),
    .cell_highlight(cell_highlight), .fg_colour(fg_colour), .bg_colour(bg_colour),
    .deinterlace_out(deinterlace_out)
  );

  sync_source sync_source_i (
    .core_clk(core_clk), .h_pol(h_pol), .v_pol(v_pol),
    .hsync_in(hsync_in), .vsync_in(vsync_in)
  );

  initial begin
    forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("reg %0d", a), 16'(exp), 16'(d));
  endtask

  // One long line: delay from sync edge to window, window width, first cell
  task automatic hline(input int hs, input bit shown, input bit hl, input logic [4:0] row);
    int n;
    int w;
    n = 0;
    w = 0;
    fork
      sync_source_i.line(5900);
      begin
        while (disp_active !== 1'b1 && n < 5800) begin
          @(posedge core_clk);
          n++;
        end
        if (shown) begin
          chk("highlight", 16'(hl), 16'(cell_highlight));
          chk("row", 16'(row), 16'(disp_row));
          chk("hstart", 16'(hs + 5), 16'((n >= hs + 3 && n <= hs + 7) ? hs + 5 : n));
          while (disp_active === 1'b1 && w < 5000) begin
            @(posedge core_clk);
            w++;
          end
          chk("width", 16'(DISPLAY_WIDTH_CYC), 16'(w));
          chk("last column", 16'(COLUMNS - 1), 16'(disp_col));
        end else begin
          chk("hidden", 16'(5800), 16'(n));
        end
      end
    join
  endtask

  // Field sync d cycles into the line, then short lines until the window opens
  task automatic vstart(input int d, input int first);
    sync_source_i.field(d, d + 100);
    k = 0;
    rv = 8'h00;
    while (rv[2] !== 1'b1 && k < 60) begin
      sync_source_i.line(20);
      k++;
      rd(ADDR_STATUS, rv);
    end
    chk("first line", 16'(first), 16'(k));
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rchk(3'(a), 8'h00);
    @(posedge core_clk);
    chk("rdata idle", 16'h0000, 16'(reg_rdata));
    for (int a = 0; a < 6; a++) wr(3'(a), wv[a]);
    wr(ADDR_STATUS, 8'hFF);
    for (int a = 0; a < 6; a++) rchk(3'(a), wv[a]);
    rchk(ADDR_STATUS, 8'h00);
    for (int a = 0; a < 6; a++) wr(3'(a), 8'h00);
    for (int i = 0; i < 16; i++) begin
      colour_lookup_table_val[i] = 6'(i * 7 + 9);
      wr(ADDR_COLOUR_LOOKUP, 8'hC0 | 8'(i));
      wr(ADDR_COLOUR_LOOKUP, {2'b01, colour_lookup_table_val[i]});
    end
    rchk(ADDR_COLOUR_LOOKUP, 8'h4F);
    for (int i = 0; i < 8; i++) begin
      fg_index <= 3'(i);
      bg_index <= 3'(7 - i);
      repeat (3) @(posedge core_clk);
      chk("fg colour", 16'(colour_lookup_table_val[i]), 16'(fg_colour));
      chk("bg colour", 16'(colour_lookup_table_val[15 - i]), 16'(bg_colour));
    end
    // Short lines reach the first display line quickly
    for (int c = 0; c < 5; c++) begin
      wr(ADDR_SYNC_CONFIG, vcfg[c]);
      wr(ADDR_DISPLAY_POSITION, vpos[c]);
      vstart(vd[c], vfirst[c]);
    end
    wr(ADDR_ACTIVE_ROW, 8'h00);
    wr(ADDR_ACTIVE_COLUMN, 8'h00);
    wr(ADDR_DISPLAY_OPTION, 8'h01);
    for (int x = 0; x < 4; x++) begin
      wr(ADDR_DISPLAY_POSITION, 8'(x));
      hline(HSTART_DEFAULT_CYC - x * HSTART_STEP_CYC, 1'b1, 1'b1, 5'h00);
    end
    wr(ADDR_DISPLAY_POSITION, 8'h00);
    wr(ADDR_SYNC_CONFIG, 8'h01);
    h_pol <= 1'b1;
    // Pin settles at its new idle level before the next pulse
    repeat (4) @(posedge core_clk);
    hline(HSTART_DEFAULT_CYC, 1'b1, 1'b1, 5'h00);
    wr(ADDR_ACTIVE_ROW, 8'h80);
    wr(ADDR_ACTIVE_COLUMN, 8'h05);
    hline(HSTART_DEFAULT_CYC, 1'b1, 1'b1, 5'h00);
    wr(ADDR_ACTIVE_ROW, 8'h00);
    hline(HSTART_DEFAULT_CYC, 1'b1, 1'b0, 5'h00);
    wr(ADDR_DISPLAY_CONTROL, 8'h01);
    hline(HSTART_DEFAULT_CYC, 1'b0, 1'b0, 5'h00);
    wr(ADDR_DISPLAY_CONTROL, 8'h00);
    wr(ADDR_DISPLAY_OPTION, 8'h06);
    // Enlarged half takes effect from the next field
    vstart(50, V625_BASE_LO);
    hline(HSTART_DEFAULT_CYC, 1'b1, 1'b0, HALF_FIRST_ROW);
    wr(ADDR_DISPLAY_OPTION, 8'h00);
    wr(ADDR_DISPLAY_CONTROL, 8'h02);
    vstart(50, V625_BASE_LO);
    repeat (int'(STATUS_ROW) * SCANS_PER_ROW) sync_source_i.line(20);
    chk("prompt row", 16'(STATUS_ROW), 16'(disp_row));
    chk("prompt ext", 16'h0001, 16'(prompt_from_ext));
    link_prompt_revert <= 1'b1;
    repeat (3) sync_source_i.line(20);
    chk("prompt revert", 16'h0000, 16'(prompt_from_ext));
    chk("scan", 16'h0003, 16'(char_scan));
    wr(ADDR_SYNC_CONFIG, 8'h02);
    h_pol <= 1'b0;
    v_pol <= 1'b1;
    // Field decision windows cut to a tenth through the instance parameters
    for (int f = 0; f < 11; f++) begin
      wr(ADDR_DISPLAY_CONTROL, fctrl[f]);
      wr(ADDR_SYNC_CONFIG, fsync[f]);
      sync_source_i.field(fd[f], 640);
      chk("deinterlace", 16'(fexp[f]), 16'(deinterlace_out));
    end
    results();
  end

  initial begin
    #900000;
    bad_count++;
    $display("ERROR watchdog expected done seen hang");
    results();
  end
endmodule
`default_nettype wire
